//--- inc/cmpc_pkg.sv
// Behaviour
// - Mode pin captured when reset releases.
// - Pin 1 normal mode, 0 special mode.
// - Mode bit readable; only special-to-normal writable.
// - Normal mode: CPU fetches after reset.
// - Special mode: debug state right after reset.
// - Debug state entered by controller request too.
// - Freeze output while debugging, if enabled.
// - Debug serial link works in stop if debug enabled.
// - Run mode clocks the whole device.
// - Wait instruction stops CPU and its clock.
// - Peripherals stay clocked in wait mode.
// - Reset, interrupt pins or irq end wait.
// - Pseudo-stop: system clocks off, oscillator on.
// - Stop: oscillator and all clocks off.
// - Only enabled stop sources wake from stop.
// - Debug enabled in stop: regulator, oscillator run.
// - Debug plus clocks-in-stop bit: all clocks on.
// - Bit clear: only debug serial clock runs.
// - Debug enabled in stop: voltage monitor on.
package cmpc_pkg;
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_WAKE_EN = 4'h4;
   localparam logic [3:0] REG_MODE    = 4'h8;
   localparam logic [3:0] REG_STATUS  = 4'hc;
   localparam int CTRL_FREEZE_BIT   = 0;
   localparam int CTRL_CLK_STOP_BIT = 1;
   localparam int CTRL_PSTOP_BIT    = 2;
   localparam int STAT_BDM_BIT      = 4;
   localparam int WAKE_SRC_W        = 5;
   localparam logic [2:0] CTRL_RESET    = 3'h0;
   localparam logic [4:0] WAKE_EN_RESET = 5'h00;
   localparam logic MODE_NORMAL  = 1'b1;
   localparam logic MODE_SPECIAL = 1'b0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] CODE_RUN     = 3'h0;
   localparam logic [2:0] CODE_WAIT    = 3'h1;
   localparam logic [2:0] CODE_PSTOP   = 3'h2;
   localparam logic [2:0] CODE_STOP    = 3'h3;
   localparam logic [2:0] CODE_RESTORE = 3'h4;
   localparam int CLK_PERIOD_NS   = 100;
   localparam int RESTORE_TIME_NS = 300;
   localparam logic [3:0] RESTORE_CYCLES =
      4'((RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [2:0] {PWR_RUN, PWR_WAIT, PWR_PSTOP, PWR_STOP, PWR_RESTORE} cmpc_pwr_type;
endpackage : cmpc_pkg

//--- hdl/cmpc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_controller (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        mode_config_pin_in,
   input  wire logic        debug_controller_en_in,
   input  wire logic        bdm_enter_req_in,
   input  wire logic        bdm_exit_req_in,
   input  wire logic        wait_instruction_in,
   input  wire logic        stop_instruction_in,
   input  wire logic        nonmaskable_irq_pin_in,
   input  wire logic        irq_pin_in,
   input  wire logic        unmasked_irq_in,
   input  wire logic [4:0]  stop_wake_src_in,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             chip_mode_value_out,
   output logic             background_debug_state_out,
   output logic             freeze_out,
   output logic             cpu_run_out,
   output logic             cpu_clk_en_out,
   output logic             bus_clk_en_out,
   output logic             periph_clk_en_out,
   output logic             lowpower_unit_clk_en_out,
   output logic             osc_en_out,
   output logic             debug_serial_clk_en_out,
   output logic             regulator_full_perf_out,
   output logic             voltage_monitor_en_out
);
   cmpc_pkg::cmpc_pwr_type state_reg;
   cmpc_pkg::cmpc_pwr_type state_next;
   logic       strap_done_reg;
   logic       mode_reg;
   logic       bdm_reg;
   logic [2:0] ctrl_reg;
   logic [4:0] wake_en_reg;
   logic [3:0] restore_cnt_reg;
   logic       wr_go;
   logic       wr_ok;
   logic       clk_stop;
   logic       dbg_stop;
   logic       stop_wake;
   logic       cpu_c;
   logic       bus_c;
   logic       per_c;
   logic       lpu_c;
   logic       osc_c;
   logic       dsc_c;
   logic       reg_c;
   logic       vm_c;

   // Write address and data are taken together on one edge, so no half write is ever held.
   assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
   assign wr_ok = wr_go && s_axi_wstrb[0];
   assign clk_stop = ctrl_reg[cmpc_pkg::CTRL_CLK_STOP_BIT];
   assign dbg_stop = debug_controller_en_in && clk_stop;
   assign stop_wake = |(stop_wake_src_in & wake_en_reg);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= cmpc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr == cmpc_pkg::REG_STATUS) ? cmpc_pkg::RESP_SLVERR
                                                                    : cmpc_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= cmpc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cmpc_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
               cmpc_pkg::REG_CTRL:    s_axi_rdata[2:0] <= ctrl_reg;
               cmpc_pkg::REG_WAKE_EN: s_axi_rdata[4:0] <= wake_en_reg;
               cmpc_pkg::REG_MODE:    s_axi_rdata[0]   <= mode_reg;
               cmpc_pkg::REG_STATUS: begin
                  s_axi_rdata[cmpc_pkg::STAT_BDM_BIT] <= bdm_reg;
                  case (state_reg)
                     cmpc_pkg::PWR_WAIT:    s_axi_rdata[2:0] <= cmpc_pkg::CODE_WAIT;
                     cmpc_pkg::PWR_PSTOP:   s_axi_rdata[2:0] <= cmpc_pkg::CODE_PSTOP;
                     cmpc_pkg::PWR_STOP:    s_axi_rdata[2:0] <= cmpc_pkg::CODE_STOP;
                     cmpc_pkg::PWR_RESTORE: s_axi_rdata[2:0] <= cmpc_pkg::CODE_RESTORE;
                     default:               s_axi_rdata[2:0] <= cmpc_pkg::CODE_RUN;
                  endcase
               end
               default: s_axi_rresp <= cmpc_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg    <= cmpc_pkg::CTRL_RESET;
         wake_en_reg <= cmpc_pkg::WAKE_EN_RESET;
      end else if (wr_ok && s_axi_awaddr == cmpc_pkg::REG_CTRL) begin
         ctrl_reg <= s_axi_wdata[2:0];
      end else if (wr_ok && s_axi_awaddr == cmpc_pkg::REG_WAKE_EN) begin
         wake_en_reg <= s_axi_wdata[4:0];
      end
   end

   // The pin cannot be loaded under the asynchronous reset, so it is caught at the first edge.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_done_reg <= 1'b0;
         mode_reg       <= cmpc_pkg::MODE_SPECIAL;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         mode_reg       <= mode_config_pin_in;
      end else if (wr_ok && s_axi_awaddr == cmpc_pkg::REG_MODE
                   && s_axi_wdata[0] == cmpc_pkg::MODE_NORMAL) begin
         mode_reg <= cmpc_pkg::MODE_NORMAL;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bdm_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         bdm_reg <= (mode_config_pin_in == cmpc_pkg::MODE_SPECIAL);
      end else if (bdm_enter_req_in && debug_controller_en_in) begin
         bdm_reg <= 1'b1;
      end else if (bdm_exit_req_in) begin
         bdm_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cmpc_pkg::PWR_RUN: begin
            if (strap_done_reg && wait_instruction_in) begin
               state_next = cmpc_pkg::PWR_WAIT;
            end else if (strap_done_reg && stop_instruction_in) begin
               state_next = ctrl_reg[cmpc_pkg::CTRL_PSTOP_BIT] ? cmpc_pkg::PWR_PSTOP
                                                               : cmpc_pkg::PWR_STOP;
            end
         end
         cmpc_pkg::PWR_WAIT: begin
            if (nonmaskable_irq_pin_in || irq_pin_in || unmasked_irq_in) begin
               state_next = cmpc_pkg::PWR_RESTORE;
            end
         end
         cmpc_pkg::PWR_PSTOP: begin
            if (unmasked_irq_in || stop_wake) begin
               state_next = cmpc_pkg::PWR_RESTORE;
            end
         end
         cmpc_pkg::PWR_STOP: begin
            if (stop_wake) begin
               state_next = cmpc_pkg::PWR_RESTORE;
            end
         end
         cmpc_pkg::PWR_RESTORE: begin
            if (restore_cnt_reg == cmpc_pkg::RESTORE_CYCLES) begin
               state_next = cmpc_pkg::PWR_RUN;
            end
         end
         default: state_next = cmpc_pkg::PWR_RUN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg       <= cmpc_pkg::PWR_RUN;
         restore_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         // The count gives the oscillator and dividers time to settle before code runs.
         if (state_reg == cmpc_pkg::PWR_RESTORE) begin
            restore_cnt_reg <= restore_cnt_reg + 4'h1;
         end else begin
            restore_cnt_reg <= 4'h0;
         end
      end
   end

   always_comb begin
      cpu_c = 1'b1;
      bus_c = 1'b1;
      per_c = 1'b1;
      lpu_c = 1'b1;
      osc_c = 1'b1;
      dsc_c = 1'b1;
      reg_c = 1'b1;
      vm_c  = 1'b1;
      case (state_reg)
         cmpc_pkg::PWR_WAIT: begin
            cpu_c = 1'b0;
         end
         cmpc_pkg::PWR_PSTOP: begin
            cpu_c = dbg_stop;
            bus_c = dbg_stop;
            per_c = dbg_stop;
            dsc_c = debug_controller_en_in;
            reg_c = debug_controller_en_in;
            vm_c  = debug_controller_en_in;
         end
         cmpc_pkg::PWR_STOP: begin
            cpu_c = dbg_stop;
            bus_c = dbg_stop;
            per_c = dbg_stop;
            lpu_c = dbg_stop;
            osc_c = debug_controller_en_in;
            dsc_c = debug_controller_en_in;
            reg_c = debug_controller_en_in;
            vm_c  = debug_controller_en_in;
         end
         cmpc_pkg::PWR_RESTORE: begin
            cpu_c = 1'b0;
         end
         default: cpu_c = 1'b1;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_clk_en_out           <= 1'b0;
         bus_clk_en_out           <= 1'b0;
         periph_clk_en_out        <= 1'b0;
         lowpower_unit_clk_en_out <= 1'b0;
         osc_en_out               <= 1'b0;
         debug_serial_clk_en_out  <= 1'b0;
         regulator_full_perf_out  <= 1'b0;
         voltage_monitor_en_out   <= 1'b0;
         cpu_run_out              <= 1'b0;
         chip_mode_value_out      <= cmpc_pkg::MODE_SPECIAL;
         background_debug_state_out <= 1'b0;
         freeze_out               <= 1'b0;
      end else begin
         cpu_clk_en_out           <= cpu_c;
         bus_clk_en_out           <= bus_c;
         periph_clk_en_out        <= per_c;
         lowpower_unit_clk_en_out <= lpu_c;
         osc_en_out               <= osc_c;
         debug_serial_clk_en_out  <= dsc_c;
         regulator_full_perf_out  <= reg_c;
         voltage_monitor_en_out   <= vm_c;
         cpu_run_out <= strap_done_reg && !bdm_reg && state_reg == cmpc_pkg::PWR_RUN;
         chip_mode_value_out <= mode_reg;
         background_debug_state_out <= bdm_reg;
         freeze_out <= bdm_reg && ctrl_reg[cmpc_pkg::CTRL_FREEZE_BIT];
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_mode_capture: assert property (
      !strap_done_reg ##1 1'b1 |-> mode_reg == $past(mode_config_pin_in)
   ) else $error("Mode bit does not hold the pin level sampled at reset release.");

   a_special_debug: assert property (
      !strap_done_reg && mode_config_pin_in == cmpc_pkg::MODE_SPECIAL
      |-> ##2 background_debug_state_out
   ) else $error("Special mode did not start in the debug state.");

   a_mode_oneway: assert property (
      strap_done_reg && mode_reg == cmpc_pkg::MODE_NORMAL |=> mode_reg == cmpc_pkg::MODE_NORMAL
   ) else $error("Mode bit left normal mode while running.");

   a_wait_cpu_off: assert property (
      state_reg == cmpc_pkg::PWR_RUN && strap_done_reg && wait_instruction_in
      |=> ##1 !cpu_clk_en_out && periph_clk_en_out
   ) else $error("Wait did not switch off the CPU clock alone.");

   a_wait_wake: assert property (
      state_reg == cmpc_pkg::PWR_WAIT && nonmaskable_irq_pin_in
      |=> state_reg == cmpc_pkg::PWR_RESTORE
   ) else $error("Interrupt pin did not end wait mode.");

   a_stop_osc: assert property (
      state_reg == cmpc_pkg::PWR_STOP && !debug_controller_en_in
      |=> !osc_en_out && !bus_clk_en_out && !voltage_monitor_en_out
   ) else $error("Stop without debug left the oscillator or clocks running.");

   a_stop_debug_clk: assert property (
      state_reg == cmpc_pkg::PWR_STOP && debug_controller_en_in && !clk_stop
      |=> debug_serial_clk_en_out && !bus_clk_en_out && !cpu_clk_en_out && regulator_full_perf_out
   ) else $error("Stop with debug did not keep only the serial clock.");

   a_stop_all_clk: assert property (
      state_reg == cmpc_pkg::PWR_STOP && dbg_stop |=> bus_clk_en_out && osc_en_out
   ) else $error("Clocks-in-stop did not keep all clocks running.");

   a_restore_len: assert property (
      $rose(state_reg == cmpc_pkg::PWR_RESTORE)
      |-> (state_reg == cmpc_pkg::PWR_RESTORE)[*4] ##1 state_reg == cmpc_pkg::PWR_RUN
   ) else $error("Restore phase did not last the settling time.");

   a_freeze_link: assert property (
      ##1 freeze_out == $past(bdm_reg && ctrl_reg[cmpc_pkg::CTRL_FREEZE_BIT])
   ) else $error("Freeze output does not follow debug state and enable.");

   a_pstop_clk: assert property (
      state_reg == cmpc_pkg::PWR_PSTOP && !dbg_stop
      |=> osc_en_out && lowpower_unit_clk_en_out && !periph_clk_en_out && !cpu_clk_en_out
   ) else $error("Pseudo-stop did not stop system clocks with the oscillator running.");

   a_run_fetch: assert property (
      state_reg == cmpc_pkg::PWR_RUN && strap_done_reg && !bdm_reg |=> cpu_run_out
   ) else $error("Core was not allowed to fetch in run mode.");

   c_wait_cycle: cover property (
      state_reg == cmpc_pkg::PWR_WAIT ##[1:20] state_reg == cmpc_pkg::PWR_RUN);
   c_stop_debug: cover property (state_reg == cmpc_pkg::PWR_STOP && dbg_stop);
   c_pstop_wake: cover property (
      state_reg == cmpc_pkg::PWR_PSTOP ##1 state_reg == cmpc_pkg::PWR_RESTORE);
   c_mode_switch: cover property ($rose(mode_reg) && strap_done_reg && $past(strap_done_reg));
endmodule : cmpc_controller
`default_nettype wire

//--- dv/cmpc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmpc_cpu_model (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic cpu_run_in,
   input  wire logic go_wait_in,
   input  wire logic go_stop_in,
   output logic      wait_instruction_out,
   output logic      stop_instruction_out
);
   // A halted core cannot execute anything, so a request is held until the core runs again.
   logic want_wait_reg;
   logic want_stop_reg;
   logic fire_wait;
   logic fire_stop;
   assign fire_wait = want_wait_reg & cpu_run_in & ~wait_instruction_out;
   assign fire_stop = want_stop_reg & cpu_run_in & ~stop_instruction_out & ~fire_wait;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         want_wait_reg        <= 1'b0;
         want_stop_reg        <= 1'b0;
         wait_instruction_out <= 1'b0;
         stop_instruction_out <= 1'b0;
      end else begin
         want_wait_reg        <= (want_wait_reg | go_wait_in) & ~fire_wait;
         want_stop_reg        <= (want_stop_reg | go_stop_in) & ~fire_stop;
         wait_instruction_out <= fire_wait;
         stop_instruction_out <= fire_stop;
      end
   end
endmodule : cmpc_cpu_model
`default_nettype wire

//--- dv/test_chip_mode_power_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_chip_mode_power_controller;
   logic        clk_in, rst_n_in, mode_pin, dbg_en, enter_req, exit_req, go_wait, go_stop;
   logic        wait_p, stop_p, nmi, irqp, uirq, mode_o, bdm_o, frz_o, run_o;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [4:0]  src;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd, seed;
   logic [1:0]  bresp, rresp, rsp;
   logic [7:0]  clkv;
   logic [3:0]  addrs [4];
   logic [31:0] rexp [4];
   int          fail_count, compares, cyc, n;

   cmpc_controller uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_config_pin_in(mode_pin),
      .debug_controller_en_in(dbg_en), .bdm_enter_req_in(enter_req), .bdm_exit_req_in(exit_req),
      .wait_instruction_in(wait_p), .stop_instruction_in(stop_p), .nonmaskable_irq_pin_in(nmi),
      .irq_pin_in(irqp), .unmasked_irq_in(uirq), .stop_wake_src_in(src),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .chip_mode_value_out(mode_o), .background_debug_state_out(bdm_o), .freeze_out(frz_o),
      .cpu_run_out(run_o), .cpu_clk_en_out(clkv[7]), .bus_clk_en_out(clkv[6]),
      .periph_clk_en_out(clkv[5]), .lowpower_unit_clk_en_out(clkv[4]), .osc_en_out(clkv[3]),
      .debug_serial_clk_en_out(clkv[2]), .regulator_full_perf_out(clkv[1]),
      .voltage_monitor_en_out(clkv[0]));

   cmpc_cpu_model cpu (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_run_in(run_o),
      .go_wait_in(go_wait), .go_stop_in(go_stop), .wait_instruction_out(wait_p),
      .stop_instruction_out(stop_p));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Expected enables {cpu,bus,periph,lowpower,osc,serial,regulator,monitor} while stopped.
   function automatic logic [7:0] exp_clk(input logic ps, input logic d, input logic c);
      if (ps) return {{3{d & c}}, 2'b11, {3{d}}};
      return d ? (c ? 8'hff : 8'h0f) : 8'h00;
   endfunction : exp_clk

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge clk_in); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk_in); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk_in);
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_in);
   endtask : axi_rd

   task automatic do_reset(input logic s);
      rst_n_in <= 1'b0;
      mode_pin <= s;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
   endtask : do_reset

   task automatic wake_wait;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (run_o !== 1'b1);
      chk(clkv, 8'hff);
      // Wake edge, a restore of RESTORE_CYCLES + 1 cycles, then the output stage.
      chk(n, cmpc_pkg::RESTORE_CYCLES + 4);
      @(posedge clk_in);
   endtask : wake_wait

   task automatic lowpower(input logic d, input logic c, input logic ps);
      logic [4:0] we;
      seed = xs(seed);
      we = (seed[4:0] == 5'h1f) ? 5'h1e : seed[4:0];
      if (we == 5'h00) we = 5'h01;
      dbg_en <= d;
      // Registers are set up before the stop instruction, never while stopped.
      axi_wr(cmpc_pkg::REG_CTRL, {29'h0, ps, c, 1'b0}, rsp);
      axi_wr(cmpc_pkg::REG_WAKE_EN, {27'h0, we}, rsp);
      go_stop <= 1'b1;
      @(posedge clk_in);
      go_stop <= 1'b0;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      chk({run_o, clkv}, {1'b0, exp_clk(ps, d, c)});
      @(posedge clk_in);
      axi_rd(cmpc_pkg::REG_STATUS, rd, rsp);
      chk({rsp, rd}, {cmpc_pkg::RESP_OKAY, 29'h0, ps ? cmpc_pkg::CODE_PSTOP : cmpc_pkg::CODE_STOP});
      src <= ~we;
      nmi <= 1'b1;
      irqp <= 1'b1;
      uirq <= ~ps;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      chk({run_o, clkv}, {1'b0, exp_clk(ps, d, c)});
      @(posedge clk_in);
      src <= (ps & seed[5]) ? 5'h00 : we;
      uirq <= ps & seed[5];
      nmi <= 1'b0;
      irqp <= 1'b0;
      wake_wait();
      src <= 5'h00;
      uirq <= 1'b0;
   endtask : lowpower

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      {rst_n_in, mode_pin, dbg_en, enter_req, exit_req, go_wait, go_stop} = 7'h00;
      {nmi, irqp, uirq, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {src, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {fail_count, compares, cyc} = '0;
      seed = 32'h23;
      addrs = '{cmpc_pkg::REG_CTRL, cmpc_pkg::REG_WAKE_EN, cmpc_pkg::REG_MODE, cmpc_pkg::REG_STATUS};
      rexp = '{32'h0, 32'h0, 32'h1, 32'h0};
      do_reset(1'b1);
      chk({mode_o, bdm_o, run_o, clkv}, {3'b101, 8'hff});
      @(posedge clk_in);
      mode_pin <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         axi_rd(addrs[i], rd, rsp);
         chk({rsp, rd}, {cmpc_pkg::RESP_OKAY, rexp[i]});
      end
      axi_rd(4'h2, rd, rsp);
      chk({rsp, rd}, {cmpc_pkg::RESP_SLVERR, 32'h0});
      axi_wr(cmpc_pkg::REG_STATUS, 32'h1f, rsp);
      chk(rsp, cmpc_pkg::RESP_SLVERR);
      wstrb <= 4'he;
      axi_wr(cmpc_pkg::REG_WAKE_EN, 32'h1f, rsp);
      wstrb <= 4'hf;
      axi_rd(cmpc_pkg::REG_WAKE_EN, rd, rsp);
      chk({rsp, rd}, {cmpc_pkg::RESP_OKAY, 32'h0});
      axi_wr(cmpc_pkg::REG_MODE, 32'h0, rsp);
      axi_rd(cmpc_pkg::REG_MODE, rd, rsp);
      chk({mode_o, rd}, {1'b1, 32'h1});
      $display("Test normal reset and registers done");
      for (int i = 0; i < 3; i++) begin
         go_wait <= 1'b1;
         @(posedge clk_in);
         go_wait <= 1'b0;
         repeat (6) @(posedge clk_in);
         @(negedge clk_in);
         chk({run_o, clkv[7:5]}, 4'h3);
         @(posedge clk_in);
         axi_rd(cmpc_pkg::REG_STATUS, rd, rsp);
         chk({rsp, rd}, {cmpc_pkg::RESP_OKAY, 29'h0, cmpc_pkg::CODE_WAIT});
         nmi <= (i == 0);
         irqp <= (i == 1);
         uirq <= (i == 2);
         wake_wait();
         {nmi, irqp, uirq} <= 3'b000;
      end
      $display("Test wait mode done");
      for (int i = 0; i < 8; i++) lowpower(i[0], i[1], i[2]);
      $display("Test stop and pseudo-stop done");
      dbg_en <= 1'b0;
      do_reset(1'b0);
      chk({mode_o, bdm_o, run_o}, 3'b010);
      @(posedge clk_in);
      axi_wr(cmpc_pkg::REG_CTRL, 32'h1, rsp);
      @(negedge clk_in);
      chk(frz_o, 1'b1);
      @(posedge clk_in);
      exit_req <= 1'b1;
      @(posedge clk_in);
      exit_req <= 1'b0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk({bdm_o, frz_o, run_o}, 3'b001);
      @(posedge clk_in);
      dbg_en <= 1'b1;
      enter_req <= 1'b1;
      @(posedge clk_in);
      enter_req <= 1'b0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk({bdm_o, frz_o, run_o}, 3'b110);
      @(posedge clk_in);
      axi_wr(cmpc_pkg::REG_MODE, 32'h1, rsp);
      @(negedge clk_in);
      chk(mode_o, 1'b1);
      $display("Test special mode and debug done");
      close_out();
   end
endmodule : test_chip_mode_power_controller
`default_nettype wire
